//--- src/pscl_pkg.sv
// Shared constants, carriers and states of the serial configuration loader.
// Assumes a single 250 MHz core clock and a synchronous active-high reset.
package pscl_pkg;
	localparam int CLK_MHZ = 250;
	// Power-on reset delay in microseconds; the figure is a plain default.
	localparam int POR_DELAY_US = 100;
	localparam int POR_CYCLES = POR_DELAY_US * CLK_MHZ;
	localparam int INIT_CYCLES = 16;
	localparam int WORD_W = 8;
	localparam int STREAM_BITS = 1024;
	// Position in the stream of the option bit that enables the init pin.
	localparam int INIT_OPT_BIT = 0;
	localparam int FIFO_DEPTH = 16;
	localparam int DONE_FALLS = 2;

	typedef struct packed {
		logic req_n;
		logic sclk;
		logic sdata;
	} pscl_pins_t;

	typedef struct packed {
		logic [WORD_W-1:0] data;
		logic last;
	} pscl_word_t;

	typedef enum logic [6:0] {
		ST_POR = 7'h01,
		ST_HOLD = 7'h02,
		ST_LOAD = 7'h04,
		ST_DONE = 7'h08,
		ST_INIT = 7'h10,
		ST_USER = 7'h20,
		ST_FAIL = 7'h40
	} pscl_state_t;
endpackage : pscl_pkg

//--- src/pscl_load.sv
// Passive serial configuration loader with its word FIFO.
// Assumes all link pins are asynchronous to clk and are synchronised here;
// open-drain lines are resolved outside from the output enables.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
module pscl_fifo #(
	parameter int W = 9,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);

	assign in_ready = !full;
	assign out_valid = wr_q != rd_q;
	assign out_data = mem_q[rd_q[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_q + (AW+1)'(push);
			rd_q <= rd_q + (AW+1)'(pop);
		end
	end
endmodule : pscl_fifo

////////////////////////////////////////////////////////////////////////////
// What this block and its host do
// [RULE1] In user mode keep all lines high; a low request restarts loading.
// [RULE2] Hold the status line low for the whole power-on reset delay.
// [RULE3] Keep load complete low from power-up through the whole load.
// [RULE4] Host keeps the serial clock driven after configuration.
// [RULE5] Ignore serial clock activity once configuration is complete.
// [RULE6] After configuration the data pin serves as a user input.
// [RULE7] Host shifts in the entire bitstream without gaps.
// [RULE8] Release load complete only after every bit arrived intact.
// [RULE9] Two falling clock edges after load complete start initialisation.
// [RULE10] Once its option bit loads, drive init done low until user mode.
// [RULE11] Capture one data bit on each rising serial clock edge.
module pscl_load #(
	parameter int POR_CYCLES = pscl_pkg::POR_CYCLES,
	parameter int STREAM_BITS = pscl_pkg::STREAM_BITS,
	parameter int INIT_CYCLES = pscl_pkg::INIT_CYCLES,
	parameter int FIFO_DEPTH = pscl_pkg::FIFO_DEPTH,
	parameter bit DUAL_PURPOSE_USER = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic reconfig_request_n,
	input wire logic serial_load_clock,
	input wire logic serial_load_data,
	output logic load_status_n_o,
	output logic load_status_n_oe,
	output logic load_complete_o,
	output logic load_complete_oe,
	output logic init_done_o,
	output logic init_done_oe,
	output logic cfg_valid,
	input wire logic cfg_ready,
	output pscl_pkg::pscl_word_t cfg_word,
	output logic user_mode,
	output logic user_data_in
);
	localparam int CW = $clog2(STREAM_BITS + 1);
	localparam int LW = $clog2(pscl_pkg::WORD_W);
	localparam logic [31:0] POR_LAST = 32'(POR_CYCLES - 1);
	localparam logic [31:0] INIT_LAST = 32'(INIT_CYCLES - 1);
	localparam logic [CW-1:0] ALL_BITS = CW'(STREAM_BITS);
	localparam logic [CW-1:0] OPT_IDX = CW'(pscl_pkg::INIT_OPT_BIT);
	localparam logic [1:0] FALL_LAST = 2'(pscl_pkg::DONE_FALLS - 1);

	pscl_pkg::pscl_pins_t pin_raw;
	pscl_pkg::pscl_pins_t s1_q;
	pscl_pkg::pscl_pins_t s2_q;
	logic sclk_prev_q;
	pscl_pkg::pscl_state_t state_q;
	pscl_pkg::pscl_state_t state_d;
	logic [31:0] timer_q;
	logic [CW-1:0] bit_cnt_q;
	logic [1:0] fall_cnt_q;
	logic [pscl_pkg::WORD_W-1:0] shift_q;
	logic push_q;
	pscl_pkg::pscl_word_t word_q;
	logic opt_q;
	logic user_data_q;
	logic fifo_in_ready;

	assign pin_raw = '{req_n: reconfig_request_n, sclk: serial_load_clock,
		sdata: serial_load_data};

	// Two-stage synchroniser; only the second stage feeds logic.
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= '{req_n: 1'b1, sclk: 1'b0, sdata: 1'b0};
			s2_q <= '{req_n: 1'b1, sclk: 1'b0, sdata: 1'b0};
			sclk_prev_q <= 1'b0;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			sclk_prev_q <= s2_q.sclk;
		end
	end

	wire sclk_rise = s2_q.sclk && !sclk_prev_q;
	wire sclk_fall = !s2_q.sclk && sclk_prev_q;
	wire in_load = state_q == pscl_pkg::ST_LOAD;
	wire take_bit = in_load && sclk_rise && bit_cnt_q != ALL_BITS; // RULE11
	wire word_end = take_bit && (&bit_cnt_q[LW-1:0]);
	wire [pscl_pkg::WORD_W-1:0] shift_d =
		{s2_q.sdata, shift_q[pscl_pkg::WORD_W-1:1]};
	wire overflow = push_q && !fifo_in_ready;
	wire all_in = bit_cnt_q == ALL_BITS && !push_q && !cfg_valid; // RULE8
	wire last_fall = sclk_fall && fall_cnt_q == FALL_LAST; // RULE9
	wire hold_state = state_q == pscl_pkg::ST_HOLD;

	always_comb begin
		state_d = state_q;
		case (state_q)
			pscl_pkg::ST_POR: begin
				if (timer_q == POR_LAST) state_d = pscl_pkg::ST_HOLD; // RULE2
			end
			pscl_pkg::ST_HOLD: begin
				if (s2_q.req_n) state_d = pscl_pkg::ST_LOAD;
			end
			pscl_pkg::ST_LOAD: begin
				if (overflow) state_d = pscl_pkg::ST_FAIL;
				else if (all_in) state_d = pscl_pkg::ST_DONE; // RULE8
			end
			pscl_pkg::ST_DONE: begin
				if (last_fall) state_d = pscl_pkg::ST_INIT; // RULE9
			end
			pscl_pkg::ST_INIT: begin
				if (timer_q == INIT_LAST) state_d = pscl_pkg::ST_USER;
			end
			pscl_pkg::ST_USER: state_d = pscl_pkg::ST_USER; // RULE5
			pscl_pkg::ST_FAIL: state_d = pscl_pkg::ST_FAIL;
			default: state_d = pscl_pkg::ST_HOLD;
		endcase
		if (state_q != pscl_pkg::ST_POR && !s2_q.req_n) begin
			state_d = pscl_pkg::ST_HOLD; // RULE1
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= pscl_pkg::ST_POR;
			timer_q <= '0;
		end else begin
			state_q <= state_d;
			timer_q <= (state_d != state_q) ? '0 : timer_q + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || hold_state) begin
			bit_cnt_q <= '0;
			fall_cnt_q <= '0;
			shift_q <= '0;
			push_q <= 1'b0;
			word_q <= '0;
			opt_q <= 1'b0;
		end else begin
			if (take_bit) bit_cnt_q <= bit_cnt_q + CW'(1); // RULE11
			if (take_bit) shift_q <= shift_d;
			push_q <= word_end;
			if (word_end) word_q <= '{data: shift_d,
				last: bit_cnt_q == ALL_BITS - CW'(1)};
			if (take_bit && bit_cnt_q == OPT_IDX) opt_q <= s2_q.sdata;
			if (state_q == pscl_pkg::ST_DONE && sclk_fall) begin
				fall_cnt_q <= fall_cnt_q + 2'h1; // RULE9
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			user_data_q <= 1'b0;
		end else begin
			user_data_q <= state_q == pscl_pkg::ST_USER && DUAL_PURPOSE_USER
				&& s2_q.sdata; // RULE6
		end
	end

	pscl_fifo #(
		.W($bits(pscl_pkg::pscl_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst || hold_state),
		.in_valid(push_q),
		.in_ready(fifo_in_ready),
		.in_data(word_q),
		.out_valid(cfg_valid),
		.out_ready(cfg_ready),
		.out_data(cfg_word)
	);

	wire past_load = state_q == pscl_pkg::ST_DONE
		|| state_q == pscl_pkg::ST_INIT || state_q == pscl_pkg::ST_USER;
	assign load_status_n_o = 1'b0;
	assign load_status_n_oe = state_q == pscl_pkg::ST_POR || hold_state
		|| state_q == pscl_pkg::ST_FAIL; // RULE2
	assign load_complete_o = 1'b0;
	assign load_complete_oe = !past_load; // RULE3
	assign init_done_o = 1'b0;
	assign init_done_oe = opt_q && state_q != pscl_pkg::ST_USER; // RULE10
	assign user_mode = state_q == pscl_pkg::ST_USER;
	assign user_data_in = user_data_q;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_user_lines_high: assert property (user_mode |-> // RULE1
		!load_status_n_oe && !load_complete_oe)
		else $error("User mode with a status line pulled low.");
	a_request_restarts: assert property ( // RULE1
		state_q != pscl_pkg::ST_POR && !s2_q.req_n
		|=> state_q == pscl_pkg::ST_HOLD && load_status_n_oe)
		else $error("Low request did not restart the load.");
	a_por_full_delay: assert property ( // RULE2
		state_q == pscl_pkg::ST_POR && state_d != pscl_pkg::ST_POR
		|-> timer_q == POR_LAST && load_status_n_oe)
		else $error("Power-on delay ended early.");
	a_complete_low_load: assert property ( // RULE3
		(in_load || state_q == pscl_pkg::ST_POR) |-> load_complete_oe)
		else $error("Load complete released during load.");
	a_clock_ignored: assert property ( // RULE5
		user_mode && s2_q.req_n
		|=> user_mode && $stable(bit_cnt_q) && $stable(fall_cnt_q))
		else $error("Serial clock disturbed user mode.");
	a_user_pin_gated: assert property (!user_mode |=> !user_data_in) // RULE6
		else $error("User data seen outside user mode.");
	a_complete_all_bits: assert property ( // RULE8
		!load_complete_oe |-> bit_cnt_q == ALL_BITS)
		else $error("Load complete released before all bits.");
	a_two_falls_init: assert property ( // RULE9
		state_q == pscl_pkg::ST_DONE && last_fall && s2_q.req_n
		|=> state_q == pscl_pkg::ST_INIT ##[1:1000] user_mode)
		else $error("Two falling edges did not start initialisation.");
	a_init_pin_low: assert property ( // RULE10
		opt_q && state_q == pscl_pkg::ST_INIT |-> init_done_oe)
		else $error("Init pin released before user mode.");
	a_bit_capture: assert property ( // RULE11
		take_bit |=> bit_cnt_q == $past(bit_cnt_q) + CW'(1))
		else $error("Rising edge did not capture a bit.");
endmodule : pscl_load

//--- tb/pscl_host.sv
// Host model that drives the serial load pins.
// Assumes the bench calls its tasks from a falling core clock edge.
`timescale 1ns/1ns
module pscl_host (
	output logic req_n,
	output logic sclk,
	output logic sdata
);
	initial begin
		req_n = 1'b1;
		sclk = 1'b0;
		sdata = 1'b0;
	end
	// The request low lasts far longer than three core clocks.
	task restart();
		#41 req_n <= 1'b0;
		#41 req_n <= 1'b1;
	endtask : restart
	// Data moves only while the clock is low; a dead line shows the inverse.
	// The final 1 ns keeps the inverse and the next bit in separate steps.
	task send_bit(input logic b);
		sdata <= b;
		#31 sclk <= 1'b1;
		#62 sclk <= 1'b0;
		#31 sdata <= ~b;
		#1;
	endtask : send_bit
	// The clock stays driven low between pulses.
	task falls(input int n);
		repeat (n) begin
			#31 sclk <= 1'b1;
			#63 sclk <= 1'b0;
			#31;
		end
	endtask : falls
	task put(input logic b);
		#31 sdata <= b;
	endtask : put
endmodule : pscl_host

//--- tb/test_passive_serial_config_load.sv
// Self-checking bench for the serial configuration loader.
// Assumes the loader, its package and tb/pscl_host.sv are compiled first.
`timescale 1ns/1ns
module test_passive_serial_config_load;
	localparam int NBITS = 136;
	localparam int W_ST = 0;
	localparam int W_CP = 1;
	localparam int W_USER = 2;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_ready = 1'b0;
	logic drain = 1'b0;
	logic req_n, sclk, sdata, st_oe, cp_oe, in_oe;
	logic st_o, cp_o, in_o;
	logic got_last[$];
	logic cfg_valid, user_mode, user_din;
	pscl_pkg::pscl_word_t cfg_word;
	int fail_count = 0;
	int num_checks = 0;
	logic [7:0] got[$];
	initial begin
		forever #2 clk = ~clk;
	end
	pscl_host host_u (.req_n(req_n), .sclk(sclk), .sdata(sdata));
	pscl_load #(.POR_CYCLES(20), .STREAM_BITS(NBITS)) dut_u (
		.clk(clk), .rst(rst), .reconfig_request_n(req_n),
		.serial_load_clock(sclk), .serial_load_data(sdata),
		.load_status_n_o(st_o), .load_status_n_oe(st_oe),
		.load_complete_o(cp_o), .load_complete_oe(cp_oe),
		.init_done_o(in_o), .init_done_oe(in_oe), .cfg_valid(cfg_valid),
		.cfg_ready(cfg_ready), .cfg_word(cfg_word),
		.user_mode(user_mode), .user_data_in(user_din));
	// The consumer stalls until drain is set, then every other cycle, so the buffer fills first.
	always @(posedge clk) begin
		if (cfg_valid && cfg_ready) begin
			got.push_back(cfg_word.data);
			got_last.push_back(cfg_word.last);
		end
		cfg_ready <= drain && !cfg_ready;
	end
	////////////////////////////////////////
	function automatic logic [7:0] byte_of(input int i);
		return (i == 0) ? 8'hA5 : 8'(i) * 8'h1D;
	endfunction : byte_of
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc
	function automatic logic probe(input int w);
		return (w == W_ST) ? st_oe : (w == W_CP) ? cp_oe : user_mode;
	endfunction : probe
	// A wait that runs out counts as a mismatch and ends the run.
	task automatic wait_for(input int w, input logic v, input int k);
		for (int i = 0; i < k && probe(w) !== v; i++) begin
			@(negedge clk);
		end
		if (probe(w) !== v) begin
			fail_count++;
			end_of_test();
		end
	endtask : wait_for
	task send_stream(input int from, input int upto);
		logic [7:0] b;
		for (int i = from; i < upto; i++) begin
			b = byte_of(i / 8);
			host_u.send_bit(b[i % 8]);
		end
	endtask : send_stream
	task end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test
	////////////////////////////////////////
	task t_por();
		cyc(10);
		chk("status_por", st_oe, 1'b1);
		chk("complete_por", cp_oe, 1'b1);
		chk("status_level", st_o, 1'b0);
		chk("complete_level", cp_o, 1'b0);
		chk("init_level", in_o, 1'b0);
		host_u.restart();
		wait_for(W_ST, 1'b0, 200);
		chk("status_ready", st_oe, 1'b0);
		$display("t_por done");
	endtask : t_por
	// The option bit is sent as 0 here, so the init pin must stay released.
	task t_overflow();
		host_u.send_bit(1'b0);
		send_stream(1, NBITS);
		cyc(10);
		chk("status_ovf", st_oe, 1'b1);
		chk("complete_ovf", cp_oe, 1'b1);
		chk("init_off", in_oe, 1'b0);
		drain = 1'b1;
		cyc(40);
		got.delete();
		got_last.delete();
		$display("t_overflow done");
	endtask : t_overflow
	task t_load();
		host_u.restart();
		wait_for(W_ST, 1'b0, 200);
		send_stream(0, NBITS - 1);
		chk("complete_mid", cp_oe, 1'b1);
		chk("init_low", in_oe, 1'b1);
		send_stream(NBITS - 1, NBITS);
		wait_for(W_CP, 1'b0, 200);
		chk("complete_rel", cp_oe, 1'b0);
		chk("words", 8'(got.size()), 8'(NBITS / 8));
		foreach (got[i]) begin
			chk("word", got[i], byte_of(i));
			chk("last", got_last[i], i == NBITS / 8 - 1);
		end
		// The buffer drains before the last data bit's clock falls, so that
		// fall already comes after release and counts as the first of two.
		cyc(24);
		chk("user_one_fall", user_mode, 1'b0);
		host_u.falls(1);
		wait_for(W_USER, 1'b1, 100);
		chk("user_entered", user_mode, 1'b1);
		chk("init_rel", in_oe, 1'b0);
		chk("status_user", st_oe, 1'b0);
		$display("t_load done");
	endtask : t_load
	task t_user();
		host_u.falls(6);
		cyc(10);
		chk("user_kept", user_mode, 1'b1);
		chk("complete_kept", cp_oe, 1'b0);
		host_u.put(1'b1);
		cyc(6);
		chk("user_pin_hi", user_din, 1'b1);
		host_u.put(1'b0);
		cyc(6);
		chk("user_pin_lo", user_din, 1'b0);
		host_u.restart();
		wait_for(W_USER, 1'b0, 100);
		chk("user_left", user_mode, 1'b0);
		chk("complete_new", cp_oe, 1'b1);
		$display("t_user done");
	endtask : t_user
	initial begin
		#150000;
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_por();
		t_overflow();
		t_load();
		t_user();
		end_of_test();
	end
endmodule : test_passive_serial_config_load
